// File: core/warmup_pll_clock_control.sv
// Clock controller: warm-up timer, multiplier control, gear select, APB.
// Assumes a same-clock stop-return pulse and oscillator ticks from pins.
//
// Function
// - Warm-up counts clock picked by select bit
// - Target is cycles with low four bits dropped
// - Fast uses main field; slow adds extension
// - Start write restarts counter from zero
// - Flag high while warming, low when reached
// - Written count reflects after delay; software polls
// - Internal oscillator enable bit turns it on
// - Stop return reinitialises clock select bits
// - Multiplier powered off after reset
// - Multiplier factor 3,4,5,6,8,10, max 80MHz
// - Select bit picks multiplied or oscillator clock
// - Gear divides 1 to 16, delayed switch
// - Source: internal, crystal or external input
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "clkctl_defines.svh"
module warmup_pll_clock_control
   import clkctl_pkg::*;
#(
   parameter logic [3:0] REFLECT_CYCLES = `REFL_DLY,
   parameter logic [3:0] GEAR_CYCLES    = `GEAR_DLY
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fast_osc_clock,
   input  wire logic        slow_osc_clock,
   input  wire logic        stop_return,
   output logic             external_osc_enable,
   output logic             internal_osc_enable,
   output logic             low_speed_osc_enable,
   output logic             osc_source_select,
   output logic             multiplier_power,
   output logic             multiplied_clock_select,
   output logic [3:0]       multiplier_factor,
   output logic [2:0]       gear_select,
   output logic             warmup_in_progress_flag,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [3:0] code_factor(input logic [14:0] code);
      unique case (code)
         15'h5917: code_factor = 4'h6;
         15'h59A6: code_factor = 4'hA;
         15'h729E: code_factor = 4'h8;
         15'h5ADF: code_factor = 4'h4;
         15'h6296: code_factor = 4'h6;
         15'h720B: code_factor = 4'h3;
         15'h3A92: code_factor = 4'h5;
         default:  code_factor = 4'h0;
      endcase
   endfunction

   // Level moves only when the two later stages agree
   function automatic logic filt(input logic [2:0] s, input logic f);
      filt = (s[1] == s[2]) ? s[2] : f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   state_s s_reg;
   state_s s_next;
   logic        setup;
   logic        wr;
   logic        hit;
   logic [13:0] target;
   logic [3:0]  ev;
   logic [3:0]  clr;
   logic [31:0] rd;
   logic        mapped;

   always_comb begin
      s_next = s_reg;
      ev     = 4'h0;
      clr    = 4'h0;
      setup  = psel & ~penable;
      wr     = psel & penable & pwrite & s_reg.pready;
      target = s_reg.wsel ? {s_reg.ext_eff, s_reg.main_eff}
                          : {2'b00, s_reg.main_eff};
      hit    = s_reg.cnt[17:`PRE_BITS] == target;

      // Oscillator edges, three-stage synchronised
      s_next.fast_s = {s_reg.fast_s[1:0], fast_osc_clock};
      s_next.slow_s = {s_reg.slow_s[1:0], slow_osc_clock};
      s_next.fast_f = filt(s_reg.fast_s, s_reg.fast_f);
      s_next.slow_f = filt(s_reg.slow_s, s_reg.slow_f);
      s_next.tick   = s_reg.wsel ? (s_next.slow_f & ~s_reg.slow_f)
                                 : (s_next.fast_f & ~s_reg.fast_f);

      // Warm-up counter
      if (s_reg.busy) begin
         if (hit) begin
            s_next.busy    = 1'b0;
            ev[`EV_DONE]   = 1'b1;
         end else if (s_reg.tick) begin
            s_next.cnt = s_reg.cnt + 18'h00001;
         end
      end

      // Count field reflects late; readback shows the reflected value, not the just-written one
      if (s_reg.refl_cnt != 4'h0) begin
         s_next.refl_cnt = s_reg.refl_cnt - 4'h1;
         if (s_reg.refl_cnt == 4'h1) begin
            s_next.main_eff = s_reg.main_wr;
            s_next.ext_eff  = s_reg.ext_wr;
         end
      end

      // Gear switch waits so the divider never glitches mid-period
      if (s_reg.gear_cnt != 4'h0) begin
         s_next.gear_cnt = s_reg.gear_cnt - 4'h1;
         if (s_reg.gear_cnt == 4'h1) begin
            s_next.gear_eff = s_reg.gear_wr;
            ev[`EV_GEAR]    = 1'b1;
         end
      end

      // Register writes
      if (wr) begin
         unique case (paddr)
            `OFF_OSC: begin
               s_next.wsel = pwdata[`B_WSEL];
               s_next.osel = pwdata[`B_OSEL];
               s_next.xext = pwdata[`B_XEXT];
               s_next.xint = pwdata[`B_XINT];
               s_next.xlow = pwdata[`B_XLOW];
               s_next.pwr  = pwdata[`B_PWR];
               s_next.main_wr  = pwdata[`B_MAIN +: 12];
               s_next.ext_wr   = pwdata[`B_EXT +: 2];
               s_next.refl_cnt = REFLECT_CYCLES;
               if (pwdata[`B_START]) begin
                  s_next.busy    = 1'b1;
                  s_next.cnt     = 18'h00000;
                  ev[`EV_START]  = 1'b1;
               end
            end
            `OFF_MSEL: begin
               s_next.msel  = pwdata[0];
               s_next.mcode = pwdata[`B_MCODE +: 15];
            end
            `OFF_SYS: begin
               if (pwdata[2:0] <= `GEAR_MAX) begin
                  s_next.gear_wr  = pwdata[2:0];
                  s_next.gear_cnt = GEAR_CYCLES;
               end
            end
            `OFF_ICLR: clr = pwdata[3:0];
            `OFF_IEN:  s_next.ien = pwdata[3:0];
            default: ;
         endcase
      end

      // Waking from stop brings the internal oscillator back as source
      if (stop_return) begin
         s_next.wsel = 1'b0;
         s_next.osel = 1'b0;
         s_next.xext = 1'b0;
         s_next.xint = `XINT_RST;
         s_next.xlow = 1'b0;
         s_next.pwr  = 1'b0;
         s_next.msel = 1'b0;
         ev[`EV_STOP] = 1'b1;
      end

      s_next.factor = code_factor(s_reg.mcode);
      s_next.ist = (s_reg.ist & ~clr) | ev;
      s_next.irq = |(s_next.ist & s_reg.ien);

      // APB read path, answered in the access cycle
      mapped = 1'b1;
      rd     = 32'h00000000;
      unique case (paddr)
         `OFF_OSC: begin
            rd[`B_WSEL] = s_reg.wsel;
            rd[`B_OSEL] = s_reg.osel;
            rd[`B_XEXT] = s_reg.xext;
            rd[`B_XINT] = s_reg.xint;
            rd[`B_XLOW] = s_reg.xlow;
            rd[`B_PWR]  = s_reg.pwr;
            rd[`B_FLAG] = s_reg.busy;
            rd[`B_EXT +: 2]   = s_reg.ext_eff;
            rd[`B_MAIN +: 12] = s_reg.main_eff;
         end
         `OFF_MSEL: rd[15:0] = {s_reg.mcode, s_reg.msel};
         `OFF_SYS:  rd[2:0]  = s_reg.gear_eff;
         `OFF_IST:  rd[3:0]  = s_reg.ist;
         `OFF_ICLR: rd       = 32'h00000000;
         `OFF_IEN:  rd[3:0]  = s_reg.ien;
         default:   mapped   = 1'b0;
      endcase
      s_next.pready  = setup;
      s_next.pslverr = setup & ~mapped;
      if (setup) begin
         s_next.prdata = rd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg      <= '0;
         s_reg.xint <= `XINT_RST;
         s_reg.pwr  <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata                  = s_reg.prdata;
   assign pready                  = s_reg.pready;
   assign pslverr                 = s_reg.pslverr;
   assign external_osc_enable     = s_reg.xext;
   assign internal_osc_enable     = s_reg.xint;
   assign low_speed_osc_enable    = s_reg.xlow;
   assign osc_source_select       = s_reg.osel;
   assign multiplier_power        = s_reg.pwr;
   assign multiplied_clock_select = s_reg.msel;
   assign multiplier_factor       = s_reg.factor;
   assign gear_select             = s_reg.gear_eff;
   assign warmup_in_progress_flag = s_reg.busy;
   assign irq                     = s_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic wr_osc;
   logic start_wr;
   assign wr_osc   = wr && (paddr == `OFF_OSC);
   assign start_wr = wr_osc && pwdata[`B_START];

   sequence wu_start_seq;
      start_wr ##1 (s_reg.busy && s_reg.cnt == 18'h00000);
   endsequence

   sequence wu_hit_seq;
      s_reg.busy && hit && !start_wr;
   endsequence

   property start_p;
      @(posedge pclk) disable iff (!presetn) start_wr |-> wu_start_seq;
   endproperty

   property done_p;
      @(posedge pclk) disable iff (!presetn) wu_hit_seq |=> !s_reg.busy && s_reg.ist[`EV_DONE];
   endproperty

   warm_start_a: assert property (start_p) else $error("start did not clear count");
   warm_done_a: assert property (done_p) else $error("flag stayed at match");
   warm_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_reg.busy && !hit && s_reg.tick && !wr_osc |=> s_reg.cnt == $past(s_reg.cnt) + 18'h1)
      else $error("count missed a tick");
   count_reflect_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_osc |=> ##[1:15] (s_reg.main_eff == s_reg.main_wr))
      else $error("count never reflected");
   stop_reinit_a: assert property (@(posedge pclk) disable iff (!presetn)
      stop_return |=> s_reg.xint && !s_reg.pwr && !s_reg.msel && !s_reg.wsel)
      else $error("stop return left bits");
   pll_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !multiplier_power)
      else $error("multiplier powered at reset");
   factor_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
      multiplier_factor inside {4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA})
      else $error("illegal multiplier factor");
   // Gear moves only when its switch delay runs out, and only to a legal ratio
   gear_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(gear_select) |-> gear_select <= `GEAR_MAX && $past(s_reg.gear_cnt) == 4'h1
                                && s_reg.ist[`EV_GEAR])
      else $error("bad gear step");
   osc_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_osc && pwdata[`B_XINT] && !stop_return |=> internal_osc_enable)
      else $error("internal oscillator not on");
   // Enable is taken one cycle late, so a clear or mask write drops irq cleanly
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(s_reg.ist & $past(s_reg.ien)))
      else $error("irq missing");

endmodule

// File: pkg/clkctl_defines.svh
// Offsets, field positions, reset values and delays of the clock controller.
// Assumes inclusion by bare name from package and core files.
`ifndef CLKCTL_DEFINES_SVH
`define CLKCTL_DEFINES_SVH
`define OFF_OSC      12'h000
`define OFF_MSEL     12'h004
`define OFF_SYS      12'h008
`define OFF_IST      12'h00C
`define OFF_ICLR     12'h010
`define OFF_IEN      12'h014
`define B_WSEL       0
`define B_OSEL       1
`define B_XEXT       2
`define B_XINT       3
`define B_XLOW       4
`define B_PWR        5
`define B_START      6
`define B_FLAG       7
`define B_EXT        8
`define B_MAIN       12
`define B_MCODE      1
`define XINT_RST     1'b1
`define EV_DONE      0
`define EV_START     1
`define EV_GEAR      2
`define EV_STOP      3
`define GEAR_MAX     3'h4
`define PRE_BITS     4
`define DLY_W        4
`define REFL_DLY     4'h4
`define GEAR_DLY     4'h8
`endif

// File: pkg/clkctl_pkg.sv
// Types shared by the clock controller.
// Assumes clkctl_defines.svh sits on the include path.
`include "clkctl_defines.svh"
package clkctl_pkg;
   typedef struct packed {
      logic        wsel;
      logic        osel;
      logic        xext;
      logic        xint;
      logic        xlow;
      logic        pwr;
      logic        msel;
      logic [14:0] mcode;
      logic [11:0] main_wr;
      logic [11:0] main_eff;
      logic [1:0]  ext_wr;
      logic [1:0]  ext_eff;
      logic [3:0]  refl_cnt;
      logic [2:0]  gear_wr;
      logic [2:0]  gear_eff;
      logic [3:0]  gear_cnt;
      logic        busy;
      logic [17:0] cnt;
      logic [2:0]  fast_s;
      logic [2:0]  slow_s;
      logic        fast_f;
      logic        slow_f;
      logic        tick;
      logic [3:0]  ist;
      logic [3:0]  ien;
      logic        irq;
      logic [3:0]  factor;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_s;
endpackage

// File: testbench/testbench.sv
// Self-checking bench of the clock controller: APB registers, warm-up, gear, multiplier.
// Assumes the design package and defines on the include path; one 200 MHz clock.
`timescale 1ns/100ps
`include "clkctl_defines.svh"
module testbench;
   import clkctl_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic        fast_osc_clock = 1'b0;
   logic        slow_osc_clock = 1'b0;
   logic        stop_return = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        external_osc_enable;
   logic        internal_osc_enable;
   logic        low_speed_osc_enable;
   logic        osc_source_select;
   logic        multiplier_power;
   logic        multiplied_clock_select;
   logic [3:0]  multiplier_factor;
   logic [2:0]  gear_select;
   logic        warmup_in_progress_flag;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   logic [31:0] seed = 32'h86A41D13;
   int          miscompares = 0;
   int          checked = 0;
   logic [5:0]  oscs;
   assign oscs = {external_osc_enable, internal_osc_enable, low_speed_osc_enable,
                  osc_source_select, multiplier_power, multiplied_clock_select};
   always #2.5 pclk = ~pclk;
   warmup_pll_clock_control #(.REFLECT_CYCLES(4'h4), .GEAR_CYCLES(4'h8)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fast_osc_clock(fast_osc_clock), .slow_osc_clock(slow_osc_clock),
      .stop_return(stop_return), .external_osc_enable(external_osc_enable),
      .internal_osc_enable(internal_osc_enable), .low_speed_osc_enable(low_speed_osc_enable),
      .osc_source_select(osc_source_select), .multiplier_power(multiplier_power),
      .multiplied_clock_select(multiplied_clock_select),
      .multiplier_factor(multiplier_factor), .gear_select(gear_select),
      .warmup_in_progress_flag(warmup_in_progress_flag), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Starts one edge later so psel never gets two assignments in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         miscompares++;
         stop_test();
      end
   endtask
   // Eight pclk per oscillator period leaves room for the 3-FF sync
   task automatic tick(input logic sl);
      if (sl) slow_osc_clock <= 1'b1;
      else fast_osc_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      if (sl) slow_osc_clock <= 1'b0;
      else fast_osc_clock <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic warm(input logic sl, input logic [1:0] x, input logic [11:0] m);
      logic [31:0] w;
      int          n;
      int          exp;
      w = {8'h00, m, 2'b00, x, 7'h04, sl};
      apb(1'b1, `OFF_OSC, w);
      n = 0;
      do begin
         apb(1'b0, `OFF_OSC, 32'h0);
         n++;
      end while ({rd[23:12], rd[9:8]} !== {m, x} && n < 12);
      check("count readback", {rd[23:12], rd[9:8]}, {m, x});
      apb(1'b1, `OFF_OSC, w | 32'h40);
      apb(1'b0, `OFF_OSC, 32'h0);
      check("flag and start bits", rd[7:6], 2'b10);
      repeat (8) tick(!sl);
      check("flag other clock", warmup_in_progress_flag, 1'b1);
      exp = sl ? {x, m} * 16 : m * 16;
      n = 0;
      while (warmup_in_progress_flag === 1'b1 && n < exp + 4) begin
         tick(sl);
         n++;
      end
      check("warm-up edges", n, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] codes [7] = '{16'h5917, 16'h59A6, 16'h729E, 16'h5ADF, 16'h6296, 16'h720B,
                              16'h3A92};
   logic [3:0]  facts [7] = '{4'h6, 4'hA, 4'h8, 4'h4, 4'h6, 4'h3, 4'h5};
   logic [2:0]  g;
   logic [2:0]  gold;
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      check("reset outputs", {oscs, multiplier_factor, gear_select, irq}, 14'h1000);
      apb(1'b0, `OFF_OSC, 32'h0);
      check("osc reset", rd, 32'h00000008);
      apb(1'b0, 12'h018, 32'h0);
      check("unmapped error", err, 1'b1);
      $display("test reset done");
      apb(1'b1, `OFF_IEN, 32'h1);
      warm(1'b0, 2'b11, 12'h001);
      warm(1'b1, 2'b00, 12'h001);
      seed = lfsr(seed);
      warm(1'b0, seed[1:0], {10'h000, seed[3:2]} + 12'h001);
      // Slow target with main field zero: only the extension keeps it warming
      apb(1'b1, `OFF_OSC, 32'h00000109);
      repeat (8) @(posedge pclk);
      apb(1'b1, `OFF_OSC, 32'h00000149);
      repeat (4) tick(1'b1);
      check("extension kept", warmup_in_progress_flag, 1'b1);
      check("irq raised", irq, 1'b1);
      apb(1'b0, `OFF_IST, 32'h0);
      check("status bits", rd[1:0], 2'b11);
      apb(1'b1, `OFF_ICLR, 32'hF);
      repeat (2) @(posedge pclk);
      check("irq cleared", irq, 1'b0);
      apb(1'b1, `OFF_IEN, 32'h0);
      warm(1'b0, 2'b00, 12'h002);
      check("irq masked", irq, 1'b0);
      $display("test warm-up done");
      gold = 3'h0;
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         g = (i == 0) ? 3'h4 : ((i == 4) ? 3'h7 : 3'(seed[7:0] % 5));
         apb(1'b1, `OFF_SYS, {29'h0, g});
         apb(1'b0, `OFF_SYS, 32'h0);
         check("gear early", rd[2:0], gold);
         if (g <= 3'h4) gold = g;
         repeat (12) @(posedge pclk);
         check("gear applied", gear_select, gold);
      end
      $display("test gear done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `OFF_MSEL, (i < 7) ? {15'h0, codes[i], 1'b0} : 32'h2468);
         repeat (2) @(posedge pclk);
         check("factor", multiplier_factor, (i < 7) ? facts[i] : 4'h0);
      end
      apb(1'b1, `OFF_MSEL, {15'h0, codes[0], 1'b0});
      apb(1'b1, `OFF_OSC, 32'h0001C028);
      apb(1'b1, `OFF_MSEL, {15'h0, codes[0], 1'b1});
      repeat (2) @(posedge pclk);
      check("pll selected", {multiplier_power, multiplied_clock_select}, 2'b11);
      apb(1'b1, `OFF_MSEL, {15'h0, codes[0], 1'b0});
      apb(1'b0, `OFF_MSEL, 32'h0);
      check("select read back", rd[0], 1'b0);
      $display("test multiplier done");
      apb(1'b1, `OFF_OSC, 32'h0001C03F);
      apb(1'b1, `OFF_MSEL, {15'h0, codes[0], 1'b1});
      repeat (2) @(posedge pclk);
      check("all sources on", oscs, 6'h3F);
      stop_return <= 1'b1;
      @(posedge pclk);
      stop_return <= 1'b0;
      @(posedge pclk);
      #1;
      check("stop return", oscs, 6'h10);
      apb(1'b0, `OFF_OSC, 32'h0);
      check("stop keeps count", rd, 32'h0001C008);
      $display("test stop return done");
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge pclk);
      miscompares++;
      stop_test();
   end
endmodule
